// ### hea_pkg.sv
// Shared constants and types for the heat energy accumulator.
package hea_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int TEMP_W = 16;
  localparam int VOL_W = 16;
  localparam int COEF_W = 16;
  localparam int ACC_W = 64;
  localparam int PROD_W = VOL_W + TEMP_W + COEF_W;

  // ----------------------------------------
  // Reset values and configuration
  // ----------------------------------------
  localparam logic [ACC_W-1:0] ACC_RST = 64'h0000_0000_0000_0000;
  // Outlet reference in hundredths of a degree, 50.00 C.
  localparam logic [TEMP_W-1:0] REF_DEFAULT = 16'h1388;
  // Scaling divisors per volume resolution code 0..3 (0.001 to 1 m3).
  localparam logic [7:0] AVG_MUL_0 = 8'h01;
  localparam logic [7:0] AVG_MUL_1 = 8'h01;
  localparam logic [7:0] AVG_MUL_2 = 8'h01;
  localparam logic [7:0] AVG_MUL_3 = 8'h01;
  // Energy unit divisors from watt-hours.
  localparam logic [31:0] DIV_KWH = 32'h0000_03E8;
  localparam logic [31:0] DIV_MWH = 32'h000F_4240;
  localparam logic [31:0] DIV_GJ = 32'h0004_3D28;

  typedef enum logic [1:0] {
    HEA_UNIT_WH,
    HEA_UNIT_KWH,
    HEA_UNIT_MWH,
    HEA_UNIT_GJ
  } hea_unit_t;

endpackage

// ### hea_mac.sv
// One guarded accumulate channel that adds a precomputed increment.
module hea_mac
  import hea_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Step
  input wire logic step,
  input wire logic enable,
  input wire logic [PROD_W-1:0] incr,
  // Result
  output logic [ACC_W-1:0] total_q
);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      total_q <= ACC_RST;
    end else if (step && enable) begin
      total_q <= total_q + ACC_W'(incr);
    end
  end

endmodule

// ### hea_accumulator.sv
// Energy and averaging accumulator datapath.
module hea_accumulator
  import hea_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Integration step from the flow front end
  input wire logic step,
  input wire logic [VOL_W-1:0] primary_volume,
  input wire logic [VOL_W-1:0] secondary_volume,
  // Temperatures and coefficients
  input wire logic signed [TEMP_W-1:0] inlet_temp,
  input wire logic signed [TEMP_W-1:0] outlet_temp,
  input wire logic signed [TEMP_W-1:0] aux_temp,
  input wire logic [COEF_W-1:0] coef_at_inlet,
  input wire logic [COEF_W-1:0] coef_at_outlet,
  // Sensor errors
  input wire logic inlet_err,
  input wire logic outlet_err,
  input wire logic aux_err,
  // Configuration
  input wire logic flow_in_outlet,
  input wire logic ref_load,
  input wire logic signed [TEMP_W-1:0] ref_value,
  input wire logic [1:0] vol_res,
  input wire logic [1:0] unit_sel,
  // Accumulators
  output logic [ACC_W-1:0] heat_energy_total,
  output logic [ACC_W-1:0] cooling_energy_total,
  output logic [ACC_W-1:0] discount_energy,
  output logic [ACC_W-1:0] surcharge_energy,
  output logic [ACC_W-1:0] inlet_avg_accum,
  output logic [ACC_W-1:0] outlet_avg_accum,
  output logic [ACC_W-1:0] aux_avg_primary_accum,
  output logic [ACC_W-1:0] aux_avg_secondary_accum,
  // Display readout
  output logic [ACC_W-1:0] heat_display_q,
  output logic dash_inlet_q,
  output logic dash_outlet_q,
  output logic dash_diff_q,
  output logic dash_power_q,
  output logic dash_aux_q,
  output logic signed [TEMP_W-1:0] outlet_temp_reference_q
);

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  // The reference is held in a register so it can be retuned in the field; reset reloads REF_DEFAULT.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outlet_temp_reference_q <= REF_DEFAULT;
    end else if (ref_load) begin
      outlet_temp_reference_q <= ref_value;
    end
  end

  // ----------------------------------------
  // Increment products
  // ----------------------------------------
  logic [COEF_W-1:0] coef;
  logic signed [TEMP_W:0] d_heat;
  logic signed [TEMP_W:0] d_disc;
  logic [TEMP_W-1:0] heat_mag;
  logic [TEMP_W-1:0] cool_mag;
  logic [TEMP_W-1:0] disc_mag;
  logic [TEMP_W-1:0] surc_mag;
  logic [PROD_W-1:0] inc_heat;
  logic [PROD_W-1:0] inc_cool;
  logic [PROD_W-1:0] inc_disc;
  logic [PROD_W-1:0] inc_surc;
  logic [PROD_W-1:0] inc_avg_in;
  logic [PROD_W-1:0] inc_avg_out;
  logic [PROD_W-1:0] inc_avg_ap;
  logic [PROD_W-1:0] inc_avg_as;
  logic [7:0] avg_div;

  assign coef = flow_in_outlet ? coef_at_outlet : coef_at_inlet;
  assign d_heat = (TEMP_W+1)'(inlet_temp) - (TEMP_W+1)'(outlet_temp);
  assign d_disc = (TEMP_W+1)'(outlet_temp_reference_q) - (TEMP_W+1)'(outlet_temp);

  always_comb begin
    heat_mag = '0;
    cool_mag = '0;
    disc_mag = '0;
    surc_mag = '0;
    if (d_heat > 0) begin
      heat_mag = TEMP_W'(d_heat);
      // Tariff split applies only while heat is being counted.
      if (d_disc > 0) begin
        disc_mag = TEMP_W'(d_disc);
      end else if (d_disc < 0) begin
        surc_mag = TEMP_W'(-d_disc);
      end
    end else if (d_heat < 0) begin
      cool_mag = TEMP_W'(-d_heat);
    end
  end

  assign inc_heat = PROD_W'(primary_volume) * PROD_W'(heat_mag) * PROD_W'(coef);
  assign inc_cool = PROD_W'(primary_volume) * PROD_W'(cool_mag) * PROD_W'(coef);
  assign inc_disc = PROD_W'(primary_volume) * PROD_W'(disc_mag) * PROD_W'(coef);
  assign inc_surc = PROD_W'(primary_volume) * PROD_W'(surc_mag) * PROD_W'(coef);

  // Average scaling per volume resolution; negative temperatures clamp to zero
  // because the accumulators are unsigned.
  always_comb begin
    case (vol_res)
      2'h0: avg_div = AVG_MUL_0;
      2'h1: avg_div = AVG_MUL_1;
      2'h2: avg_div = AVG_MUL_2;
      2'h3: avg_div = AVG_MUL_3;
      default: avg_div = AVG_MUL_0;
    endcase
  end

  function automatic logic [PROD_W-1:0] avg_prod(input logic [VOL_W-1:0] v,
                                                  input logic signed [TEMP_W-1:0] t,
                                                  input logic [7:0] dv);
    logic [PROD_W-1:0] p;
    p = t[TEMP_W-1] ? '0 : PROD_W'(v) * PROD_W'(t[TEMP_W-2:0]);
    return p / PROD_W'(dv);
  endfunction

  assign inc_avg_in = avg_prod(primary_volume, inlet_temp, avg_div);
  assign inc_avg_out = avg_prod(primary_volume, outlet_temp, avg_div);
  assign inc_avg_ap = avg_prod(primary_volume, aux_temp, avg_div);
  assign inc_avg_as = avg_prod(secondary_volume, aux_temp, avg_div);

  // ----------------------------------------
  // Accumulators, all updated on the same step edge
  // ----------------------------------------
  logic ok_io;
  assign ok_io = !inlet_err && !outlet_err;

  hea_mac u_heat (.clk(clk), .rst(rst), .step(step), .enable(ok_io), .incr(inc_heat),
                  .total_q(heat_energy_total));
  hea_mac u_cool (.clk(clk), .rst(rst), .step(step), .enable(ok_io), .incr(inc_cool),
                  .total_q(cooling_energy_total));
  hea_mac u_disc (.clk(clk), .rst(rst), .step(step), .enable(ok_io), .incr(inc_disc),
                  .total_q(discount_energy));
  hea_mac u_surc (.clk(clk), .rst(rst), .step(step), .enable(ok_io), .incr(inc_surc),
                  .total_q(surcharge_energy));
  hea_mac u_avin (.clk(clk), .rst(rst), .step(step), .enable(!inlet_err), .incr(inc_avg_in),
                  .total_q(inlet_avg_accum));
  hea_mac u_avout (.clk(clk), .rst(rst), .step(step), .enable(!outlet_err), .incr(inc_avg_out),
                   .total_q(outlet_avg_accum));
  hea_mac u_avap (.clk(clk), .rst(rst), .step(step), .enable(!aux_err), .incr(inc_avg_ap),
                  .total_q(aux_avg_primary_accum));
  hea_mac u_avas (.clk(clk), .rst(rst), .step(step), .enable(!aux_err), .incr(inc_avg_as),
                  .total_q(aux_avg_secondary_accum));

  // ----------------------------------------
  // Display readout
  // ----------------------------------------
  logic [31:0] unit_div;
  always_comb begin
    case (hea_unit_t'(unit_sel))
      HEA_UNIT_KWH: unit_div = DIV_KWH;
      HEA_UNIT_MWH: unit_div = DIV_MWH;
      HEA_UNIT_GJ: unit_div = DIV_GJ;
      default: unit_div = 32'h0000_0001;
    endcase
  end

  // A divider this wide is costly; a real meter would iterate, here it is
  // kept combinational for one-cycle readout.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      heat_display_q <= ACC_RST;
    end else begin
      heat_display_q <= heat_energy_total / ACC_W'(unit_div);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dash_inlet_q <= 1'b0;
      dash_outlet_q <= 1'b0;
      dash_diff_q <= 1'b0;
      dash_power_q <= 1'b0;
      dash_aux_q <= 1'b0;
    end else begin
      dash_inlet_q <= inlet_err;
      dash_outlet_q <= outlet_err;
      dash_diff_q <= inlet_err || outlet_err;
      dash_power_q <= inlet_err || outlet_err;
      dash_aux_q <= aux_err;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_equal_no_heat;
    @(posedge clk) disable iff (rst)
      (step && inlet_temp == outlet_temp) |=> $stable(heat_energy_total) && $stable(discount_energy)
      && $stable(surcharge_energy);
  endproperty
  a_equal_no_heat: assert property (p_equal_no_heat) else $error("heat counted at equal temps");

  property p_heat_step;
    @(posedge clk) disable iff (rst)
      (step && ok_io) |=> heat_energy_total == $past(heat_energy_total) + ACC_W'($past(inc_heat));
  endproperty
  a_heat_step: assert property (p_heat_step) else $error("heat increment wrong");

  property p_cool_only_when_colder;
    @(posedge clk) disable iff (rst)
      (step && inlet_temp >= outlet_temp) |=> $stable(cooling_energy_total);
  endproperty
  a_cool_only_when_colder: assert property (p_cool_only_when_colder) else $error("cooling counted");

  property p_disc_surc_exclusive;
    @(posedge clk) disable iff (rst)
      step |=> $stable(discount_energy) || $stable(surcharge_energy);
  endproperty
  a_disc_surc_exclusive: assert property (p_disc_surc_exclusive) else $error("both tariffs counted");

  property p_ref_zero;
    @(posedge clk) disable iff (rst)
      (step && outlet_temp == outlet_temp_reference_q) |=> $stable(discount_energy)
      && $stable(surcharge_energy);
  endproperty
  a_ref_zero: assert property (p_ref_zero) else $error("tariff counted at zero difference");

  property p_ref_load;
    @(posedge clk) disable iff (rst)
      ref_load |=> outlet_temp_reference_q == $past(ref_value);
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("reference not loaded");

  property p_avg_in;
    @(posedge clk) disable iff (rst)
      (step && !inlet_err) |=> inlet_avg_accum == $past(inlet_avg_accum) + ACC_W'($past(inc_avg_in));
  endproperty
  a_avg_in: assert property (p_avg_in) else $error("inlet average wrong");

  property p_aux_err_stop;
    @(posedge clk) disable iff (rst)
      (step && aux_err) |=> $stable(aux_avg_primary_accum) && $stable(aux_avg_secondary_accum);
  endproperty
  a_aux_err_stop: assert property (p_aux_err_stop) else $error("aux average counted in error");

  property p_io_err_stop;
    @(posedge clk) disable iff (rst)
      (step && inlet_err) |=> $stable(heat_energy_total) && $stable(cooling_energy_total)
      && $stable(inlet_avg_accum);
  endproperty
  a_io_err_stop: assert property (p_io_err_stop) else $error("counted with inlet error");

  property p_dash;
    @(posedge clk) disable iff (rst)
      outlet_err |=> dash_outlet_q && dash_diff_q && dash_power_q;
  endproperty
  a_dash: assert property (p_dash) else $error("dashes missing");

  property p_idle_hold;
    @(posedge clk) disable iff (rst)
      !step |=> $stable(heat_energy_total) && $stable(inlet_avg_accum) && $stable(aux_avg_secondary_accum);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("accumulator moved without step");

  property p_avg_out;
    @(posedge clk) disable iff (rst)
      (step && !outlet_err) |=> outlet_avg_accum == $past(outlet_avg_accum)
      + ACC_W'($past(inc_avg_out));
  endproperty
  a_avg_out: assert property (p_avg_out) else $error("outlet average wrong");

  property p_avg_aux;
    @(posedge clk) disable iff (rst)
      (step && !aux_err) |=> aux_avg_secondary_accum == $past(aux_avg_secondary_accum)
      + ACC_W'($past(inc_avg_as));
  endproperty
  a_avg_aux: assert property (p_avg_aux) else $error("aux secondary average wrong");

  property p_out_err_stop;
    @(posedge clk) disable iff (rst)
      (step && outlet_err) |=> $stable(heat_energy_total) && $stable(discount_energy)
      && $stable(surcharge_energy) && $stable(outlet_avg_accum);
  endproperty
  a_out_err_stop: assert property (p_out_err_stop) else $error("counted with outlet error");

  // The display lags the total by one register, so it is held against the
  // total one cycle earlier.
  property p_display_kwh;
    @(posedge clk) disable iff (rst)
      (unit_sel == 2'h1) |=> heat_display_q == $past(heat_energy_total) / ACC_W'(DIV_KWH);
  endproperty
  a_display_kwh: assert property (p_display_kwh) else $error("kWh display wrong");

endmodule

// ### hea_front_model.sv
// Flow and temperature front end model that issues integration steps.
module hea_front_model
  import hea_pkg::*;
(
  // Clock
  input wire logic clk,
  // Step and its measurements
  output logic step,
  output logic [VOL_W-1:0] primary_volume,
  output logic [VOL_W-1:0] secondary_volume,
  output logic signed [TEMP_W-1:0] inlet_temp,
  output logic signed [TEMP_W-1:0] outlet_temp,
  output logic signed [TEMP_W-1:0] aux_temp
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    step = 1'b0;
    {primary_volume, secondary_volume, inlet_temp, outlet_temp, aux_temp} = '0;
  end

  // Measurements are only valid with the step; afterwards, unless hold is set, they are inverted so
  // a design that samples late picks up wrong values.
  task automatic send(input int v1, v2, t1, t2, t3, input bit hold);
    if (!step) begin
      @(posedge clk);
      #1;
    end
    step = 1'b1;
    primary_volume = v1[VOL_W-1:0];
    secondary_volume = v2[VOL_W-1:0];
    inlet_temp = t1[TEMP_W-1:0];
    outlet_temp = t2[TEMP_W-1:0];
    aux_temp = t3[TEMP_W-1:0];
    @(posedge clk);
    #1;
    if (!hold) begin
      step = 1'b0;
      {primary_volume, secondary_volume, inlet_temp, outlet_temp, aux_temp} =
        ~{primary_volume, secondary_volume, inlet_temp, outlet_temp, aux_temp};
    end
  endtask
endmodule

// ### hea_accumulator_tb.sv
// Self-checking testbench for the heat energy accumulator.
module hea_accumulator_tb
  import hea_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst, step, inlet_err, outlet_err, aux_err, flow_in_outlet, ref_load;
  logic [VOL_W-1:0] primary_volume, secondary_volume;
  logic signed [TEMP_W-1:0] inlet_temp, outlet_temp, aux_temp, ref_value, outlet_temp_reference_q;
  logic [COEF_W-1:0] coef_at_inlet, coef_at_outlet;
  logic [1:0] vol_res, unit_sel;
  logic [ACC_W-1:0] acc [8];
  logic [ACC_W-1:0] heat_display_q;
  logic dash_inlet_q, dash_outlet_q, dash_diff_q, dash_power_q, dash_aux_q;
  longint exp_acc [8];
  longint divs [4];
  int ref_e, n_errors, checked;

  hea_front_model i_fe (.clk(clk), .step(step), .primary_volume(primary_volume),
    .secondary_volume(secondary_volume), .inlet_temp(inlet_temp), .outlet_temp(outlet_temp),
    .aux_temp(aux_temp));

  hea_accumulator i_dut (.clk(clk), .rst(rst), .step(step), .primary_volume(primary_volume),
    .secondary_volume(secondary_volume), .inlet_temp(inlet_temp), .outlet_temp(outlet_temp),
    .aux_temp(aux_temp), .coef_at_inlet(coef_at_inlet), .coef_at_outlet(coef_at_outlet),
    .inlet_err(inlet_err), .outlet_err(outlet_err), .aux_err(aux_err),
    .flow_in_outlet(flow_in_outlet), .ref_load(ref_load), .ref_value(ref_value),
    .vol_res(vol_res), .unit_sel(unit_sel), .heat_energy_total(acc[0]),
    .cooling_energy_total(acc[1]), .discount_energy(acc[2]), .surcharge_energy(acc[3]),
    .inlet_avg_accum(acc[4]), .outlet_avg_accum(acc[5]), .aux_avg_primary_accum(acc[6]),
    .aux_avg_secondary_accum(acc[7]), .heat_display_q(heat_display_q),
    .dash_inlet_q(dash_inlet_q), .dash_outlet_q(dash_outlet_q), .dash_diff_q(dash_diff_q),
    .dash_power_q(dash_power_q), .dash_aux_q(dash_aux_q),
    .outlet_temp_reference_q(outlet_temp_reference_q));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [ACC_W-1:0] e, g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", name, e, g);
    end
  endtask

  // The expected set is advanced from the step's inputs before the step is sent.
  task automatic do_step(input int v1, v2, t1, t2, t3, input bit hold = 1'b0);
    longint k;
    bit ok;
    k = flow_in_outlet ? coef_at_outlet : coef_at_inlet;
    ok = !inlet_err && !outlet_err;
    if (ok && t1 > t2) begin
      exp_acc[0] += v1 * (t1 - t2) * k;
      if (ref_e > t2) exp_acc[2] += v1 * (ref_e - t2) * k;
      if (t2 > ref_e) exp_acc[3] += v1 * (t2 - ref_e) * k;
    end
    if (ok && t1 < t2) exp_acc[1] += v1 * (t2 - t1) * k;
    if (!inlet_err && t1 > 0) exp_acc[4] += v1 * t1;
    if (!outlet_err && t2 > 0) exp_acc[5] += v1 * t2;
    if (!aux_err && t3 > 0) begin
      exp_acc[6] += v1 * t3;
      exp_acc[7] += v2 * t3;
    end
    i_fe.send(v1, v2, t1, t2, t3, hold);
    foreach (exp_acc[i]) chk($sformatf("acc%0d", i), exp_acc[i], acc[i]);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    foreach (acc[i]) chk("acc_rst", '0, acc[i]);
    chk("ref_rst", REF_DEFAULT, outlet_temp_reference_q);
  endtask

  task automatic t_heat();
    do_step(2, 3, 7000, 3000, 1500);
    flow_in_outlet = 1'b1;
    do_step(2, 3, 7000, 5500, -200);
    do_step(4, 1, 6000, 6000, 900);
    do_step(4, 1, 6000, 5000, 900);
    do_step(3, 2, 2000, 4500, 800);
  endtask

  task automatic t_err();
    for (int e = 0; e < 3; e++) begin
      {aux_err, outlet_err, inlet_err} = 3'b001 << e;
      do_step(2, 2, 7000, 3000, 1000);
      do_step(2, 2, 3000, 7000, 1000);
      chk("dash_in", inlet_err, dash_inlet_q);
      chk("dash_out", outlet_err, dash_outlet_q);
      chk("dash_diff", inlet_err | outlet_err, dash_diff_q);
      chk("dash_pow", inlet_err | outlet_err, dash_power_q);
      chk("dash_aux", aux_err, dash_aux_q);
    end
    {aux_err, outlet_err, inlet_err} = 3'b000;
  endtask

  task automatic t_ref();
    ref_value = 16'sh0FA0;
    ref_load = 1'b1;
    @(posedge clk);
    #1;
    ref_load = 1'b0;
    ref_e = 4000;
    @(posedge clk);
    #1;
    chk("ref", 64'h0000_0000_0000_0FA0, outlet_temp_reference_q);
    do_step(1, 1, 9000, 4500, 100);
    do_step(1, 1, 8000, 2000, 300, 1);
    do_step(2, 1, 1000, 3000, 300, 1);
    do_step(1, 2, 5000, 4000, -5);
  endtask

  // A reader snapshots the inlet average and the volume together, then
  // divides the two deltas to get the volume-weighted inlet temperature.
  task automatic t_avg();
    longint acc0, vol;
    acc0 = acc[4];
    vol = 0;
    for (int i = 1; i < 4; i++) begin
      vol += i;
      do_step(i, 1, 6250, 3000, 100);
    end
    chk("avg_in", 6250, (acc[4] - acc0) / vol);
  endtask

  task automatic t_units();
    for (int r = 0; r < 4; r++) begin
      vol_res = r[1:0];
      do_step(1, 1, 5000, 4000, 200);
    end
    coef_at_outlet = 16'h03E8;
    do_step(100, 0, 10000, 0, 0);
    for (int u = 0; u < 4; u++) begin
      unit_sel = u[1:0];
      repeat (2) @(posedge clk);
      #1;
      chk("display", exp_acc[0] / divs[u], heat_display_q);
    end
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic conclude();
    $display("Errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The whole sequence needs under a hundred cycles; the 5000-cycle limit is ample margin.
  initial begin
    #50000;
    n_errors++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    {inlet_err, outlet_err, aux_err, flow_in_outlet, ref_load} = '0;
    ref_value = 16'sh0000;
    coef_at_inlet = 16'h0003;
    coef_at_outlet = 16'h0005;
    vol_res = 2'h0;
    unit_sel = 2'h0;
    divs = '{1, DIV_KWH, DIV_MWH, DIV_GJ};
    exp_acc = '{default: 0};
    ref_e = 5000;
    repeat (16) @(posedge clk);
    #1;
    t_reset();
    rst = 1'b0;
    t_heat();
    t_err();
    t_ref();
    t_avg();
    t_units();
    rst = 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    conclude();
  end
endmodule
